// ===== tb/bbf_exec_unit_assertions.sv
// port-level checker for the execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bbf_consts.vh"
`include "bbf_tb_cond.svh"
module bbf_exec_chk #(
    parameter IO_COUNT = 32,
    parameter REG_COUNT = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // issue side
    input wire logic instr_valid,
    input wire logic [5:0] instr_op,
    input wire logic [6:0] instr_offset,
    // results
    input wire logic instr_ready,
    input wire logic retire,
    input wire logic [15:0] pc_out,
    input wire logic [7:0] status_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // accepted issue, split by class of operation
    wire logic take = instr_valid && instr_ready;
    wire logic is_br = take && (instr_op <= `BBF_OP_BR_LAST);
    wire logic is_io = take && (instr_op[5:1] == 5'h08);
    wire logic is_flag = take && (instr_op[5:4] == 2'h2);
    wire logic is_sh = take && instr_op >= 6'h12 && instr_op <= 6'h16;
    wire logic is_bst = take && instr_op == `BBF_OP_STORE_BIT_TO_TRANSFER;
    wire logic keep_fl = take && instr_op >= 6'h18 && instr_op <= 6'h1b;
    wire logic single = take && !is_br && !is_io;
    wire logic br_go = bbf_br_cond(instr_op, status_out);
    // jump target seen with the status and pc of the issue cycle
    wire logic [15:0] tgt = pc_out + {{9{instr_offset[6]}}, instr_offset} + 16'h0001;

    property p_br_taken;
        is_br && br_go |=> pc_out == $past(tgt) && !instr_ready && !retire ##1 instr_ready && retire;
    endproperty
    a_br_taken: assert property (p_br_taken)
        else $error("taken branch target or timing wrong");
    property p_br_skip;
        is_br && !br_go |=> pc_out == $past(pc_out) + 16'h0001 && retire && instr_ready;
    endproperty
    a_br_skip: assert property (p_br_skip)
        else $error("untaken branch wrong");
    property p_br_flags;
        is_br |=> $stable(status_out) ##1 ($past(instr_ready) || $stable(status_out));
    endproperty
    a_br_flags: assert property (p_br_flags)
        else $error("branch changed status");
    property p_io_two;
        is_io |=> !instr_ready && !retire && $stable(status_out) ##1 instr_ready && retire;
    endproperty
    a_io_two: assert property (p_io_two)
        else $error("io bit op timing or status wrong");
    property p_one_cycle;
        single |=> retire && instr_ready && pc_out == $past(pc_out) + 16'h0001;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("single cycle op wrong");
    property p_flag_op;
        is_flag |=> status_out[$past(instr_op[2:0])] == $past(instr_op[3])
            && ((status_out ^ $past(status_out)) & ~(8'h01 << $past(instr_op[2:0]))) == 8'h00;
    endproperty
    a_flag_op: assert property (p_flag_op)
        else $error("flag op wrong");
    property p_keep_flags;
        keep_fl |=> $stable(status_out);
    endproperty
    a_keep_flags: assert property (p_keep_flags)
        else $error("move or bit load changed status");
    property p_shift_flags;
        is_sh |=> status_out[7:4] == $past(status_out[7:4])
            && status_out[3] == (status_out[2] ^ status_out[0]);
    endproperty
    a_shift_flags: assert property (p_shift_flags)
        else $error("shift flags wrong");
    property p_bst;
        is_bst |=> (status_out & 8'hbf) == ($past(status_out) & 8'hbf);
    endproperty
    a_bst: assert property (p_bst)
        else $error("bit store touched other flags");
    property p_reset;
        disable iff (1'b0) reset |=> pc_out == 16'h0000 && status_out == 8'h00 && !retire;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");
endmodule // bbf_exec_chk

bind bbf_exec_unit bbf_exec_chk #(.IO_COUNT(IO_COUNT), .REG_COUNT(REG_COUNT)) u_bbf_exec_chk (
    .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_offset(instr_offset), .instr_ready(instr_ready), .retire(retire),
    .pc_out(pc_out), .status_out(status_out));
`default_nettype wire

// ===== tb/bbf_tb_cond.svh
// branch condition reference shared by the bench and the checker
`ifndef BBF_TB_COND_SVH
`define BBF_TB_COND_SVH
// true when a branch op would jump for the given status byte
function automatic logic bbf_br_cond(input logic [5:0] op, input logic [7:0] st);
    logic f;
    case (op[3:1])
        3'h0: f = st[0];
        3'h1: f = st[2];
        3'h2: f = st[2] ^ st[3];
        3'h3: f = st[5];
        3'h4: f = st[6];
        3'h5: f = st[3];
        default: f = st[7];
    endcase
    // carry and signed pairs jump on a match of the low op bit, the rest on a mismatch
    bbf_br_cond = (op[3:1] == 3'h0 || op[3:1] == 3'h2) ? (f == op[0]) : (f != op[0]);
endfunction
`endif

// ===== tb/tb_bbf_exec_unit.sv
// self-checking bench for the branch, bit and flag execution unit
`timescale 1ns/1ns
`default_nettype none
`include "bbf_consts.vh"
`include "bbf_tb_cond.svh"
module tb_bbf_exec_unit;
    // stimulus, all driven at the falling edge
    logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
    logic [5:0] instr_op = 6'h00;
    logic [4:0] instr_rd = 5'h00, instr_rr = 5'h00, instr_io = 5'h00, reg_sel = 5'h00, io_sel = 5'h00;
    logic [2:0] instr_bit = 3'h0;
    logic [7:0] instr_imm = 8'h00, st_keep;
    logic [6:0] instr_offset = 7'h00;
    wire logic instr_ready, retire;
    wire logic [15:0] pc_out;
    wire logic [7:0] status_out, reg_data, io_data;
    int n_mismatch = 0, n_tests = 0;
    logic [15:0] pc_exp = 16'h0000;

    bbf_exec_unit u_bbf_exec_unit (.clk(clk), .reset(reset), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_rd(instr_rd), .instr_rr(instr_rr), .instr_bit(instr_bit),
        .instr_imm(instr_imm), .instr_offset(instr_offset), .instr_io(instr_io),
        .reg_sel(reg_sel), .io_sel(io_sel), .instr_ready(instr_ready), .retire(retire),
        .pc_out(pc_out), .status_out(status_out), .reg_data(reg_data), .io_data(io_data));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // issue one op at a falling edge, then judge retire, ready and pc; io ops and
    // taken branches hold ready low for exactly one extra cycle
    task automatic run(input logic [5:0] op, input logic [4:0] rd, input logic [4:0] rr,
                       input logic [2:0] b, input logic [7:0] imm, input logic [6:0] off,
                       input logic jump);
        int i;
        logic slow;
        // an idle edge between ops, so valid is never lowered and raised in one step
        @(negedge clk);
        i = 0;
        while (instr_ready !== 1'b1 && i < 8) begin
            @(negedge clk);
            i++;
        end
        if (i == 8) begin
            chk("ready wait", 16'h0001, 16'h0000);
            report_and_stop();
        end
        slow = jump || op == `BBF_OP_SET_IO_BIT || op == `BBF_OP_CLEAR_IO_BIT;
        pc_exp = pc_exp + (jump ? {{9{off[6]}}, off} : 16'h0000) + 16'h0001;
        {instr_op, instr_rd, instr_io, instr_rr, instr_bit} = {op, rd, rd, rr, b};
        {instr_imm, instr_offset, instr_valid} = {imm, off, 1'b1};
        @(posedge clk);
        @(negedge clk);
        instr_valid = 1'b0;
        if (slow) begin
            chk("ready c1", 16'h0000, {15'h0, instr_ready});
            chk("retire c1", 16'h0000, {15'h0, retire});
            @(negedge clk);
        end
        chk("retire", 16'h0001, {15'h0, retire});
        chk("ready", 16'h0001, {15'h0, instr_ready});
        chk("pc", pc_exp, pc_out);
    endtask

    // read back a register or io register through the one-cycle observation port
    task automatic see(input logic io, input logic [4:0] a, input logic [7:0] e);
        reg_sel = a;
        io_sel = a;
        @(negedge clk);
        chk(io ? "io" : "reg", {8'h00, e}, {8'h00, io ? io_data : reg_data});
    endtask

    // drive the whole status byte with eight single-flag ops
    task automatic set_status(input logic [7:0] st);
        for (int i = 0; i < 8; i++) run({2'h2, st[i], i[2:0]}, 5'h00, 5'h00, 3'h0, 8'h00, 7'h00,
            1'b0);
    endtask

    task automatic t_flags();
        logic [7:0] pat [4] = '{8'hff, 8'h00, 8'h55, 8'haa};
        foreach (pat[j]) begin
            set_status(pat[j]);
            chk("status", {8'h00, pat[j]}, {8'h00, status_out});
        end
    endtask

    // every branch op against four status patterns, offsets at both extremes
    task automatic t_branch();
        logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
        foreach (pat[j]) begin
            set_status(pat[j]);
            for (int k = 0; k <= 13; k++) begin
                run(k[5:0], 5'h00, 5'h00, 3'h0, 8'h00, k[0] ? 7'h40 : 7'h3f,
                    bbf_br_cond(k[5:0], pat[j]));
                chk("status kept", {8'h00, pat[j]}, {8'h00, status_out});
            end
        end
    endtask

    task automatic t_shift();
        logic [7:0] v [4] = '{8'h81, 8'h80, 8'h01, 8'h40};
        logic [7:0] r;
        logic c;
        for (int s = 0; s < 5; s++) begin
            foreach (v[j]) begin
                set_status({4'hf, 3'h0, j[0]});
                run(`BBF_OP_LOAD_IMMEDIATE, 5'h05, 5'h00, 3'h0, v[j], 7'h00, 1'b0);
                run(`BBF_OP_SHIFT_LEFT_LOGICAL + s[5:0], 5'h05, 5'h00, 3'h0, 8'h00, 7'h00,
                    1'b0);
                case (s)
                    0: {r, c} = {v[j][6:0], 1'b0, v[j][7]};
                    1: {r, c} = {1'b0, v[j][7:1], v[j][0]};
                    2: {r, c} = {v[j][6:0], j[0], v[j][7]};
                    3: {r, c} = {j[0], v[j][7:1], v[j][0]};
                    default: {r, c} = {v[j][7], v[j][7:1], v[j][0]};
                endcase
                see(1'b0, 5'h05, r);
                chk("shift flags", {12'h00f, r[7] ^ c, r[7], r == 8'h00, c},
                    {8'h00, status_out});
            end
        end
    endtask

    task automatic t_bits();
        run(`BBF_OP_LOAD_IMMEDIATE, 5'h03, 5'h00, 3'h0, 8'ha5, 7'h00, 1'b0);
        run(`BBF_OP_LOAD_IMMEDIATE, 5'h04, 5'h00, 3'h0, 8'h5a, 7'h00, 1'b0);
        for (int b = 0; b < 8; b++) begin
            run(`BBF_OP_STORE_BIT_TO_TRANSFER, 5'h00, 5'h03, b[2:0], 8'h00, 7'h00,
                1'b0);
            // bit b of 8'ha5: low nibble set on even b, high nibble on odd b
            chk("transfer", {15'h0, b[0] ~^ b[2]}, {15'h0, status_out[6]});
            run(`BBF_OP_LOAD_BIT_FROM_TRANSFER, 5'h04, 5'h00, b[2:0], 8'h00, 7'h00,
                1'b0);
        end
        see(1'b0, 5'h04, 8'ha5);
    endtask

    task automatic t_io_moves();
        st_keep = status_out;
        run(`BBF_OP_SET_IO_BIT, 5'h1f, 5'h00, 3'h7, 8'h00, 7'h00, 1'b0);
        run(`BBF_OP_SET_IO_BIT, 5'h1f, 5'h00, 3'h0, 8'h00, 7'h00, 1'b0);
        run(`BBF_OP_CLEAR_IO_BIT, 5'h1f, 5'h00, 3'h0, 8'h00, 7'h00, 1'b0);
        see(1'b1, 5'h1f, 8'h80);
        see(1'b1, 5'h1e, 8'h00);
        run(`BBF_OP_LOAD_IMMEDIATE, 5'h10, 5'h00, 3'h0, 8'h3c, 7'h00, 1'b0);
        run(`BBF_OP_LOAD_IMMEDIATE, 5'h11, 5'h00, 3'h0, 8'hc3, 7'h00, 1'b0);
        run(`BBF_OP_COPY_REGISTER, 5'h02, 5'h10, 3'h0, 8'h00, 7'h00, 1'b0);
        run(`BBF_OP_COPY_REGISTER_PAIR, 5'h09, 5'h11, 3'h0, 8'h00, 7'h00, 1'b0);
        see(1'b0, 5'h02, 8'h3c);
        see(1'b0, 5'h08, 8'h3c);
        see(1'b0, 5'h09, 8'hc3);
        chk("status kept", {8'h00, st_keep}, {8'h00, status_out});
    endtask

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_flags();
        t_branch();
        t_shift();
        t_bits();
        t_io_moves();
        report_and_stop();
    end
endmodule // tb_bbf_exec_unit
`default_nettype wire

// ===== verilog/bbf_consts.vh
// constants shared by the branch, bit and flag execution unit
`ifndef BBF_CONSTS_VH
`define BBF_CONSTS_VH

// ------------------------------------------------------------
// widths, reset values, pc step and offset sign bit
// ------------------------------------------------------------
`define BBF_OP_W 6
`define BBF_PC_W 16
`define BBF_PC_RESET 16'h0000
`define BBF_PC_STEP 16'h0001
`define BBF_STATUS_RESET 8'h00
`define BBF_REG_RESET 8'h00
`define BBF_OFF_SIGN 6

// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define BBF_FLAG_C 0
`define BBF_FLAG_Z 1
`define BBF_FLAG_N 2
`define BBF_FLAG_V 3
`define BBF_FLAG_S 4
`define BBF_FLAG_H 5
`define BBF_FLAG_T 6
`define BBF_FLAG_I 7

// ------------------------------------------------------------
// operation codes: conditional branches
// ------------------------------------------------------------
`define BBF_OP_BR_SAME_OR_HIGHER 6'h00
`define BBF_OP_BR_LOWER 6'h01
`define BBF_OP_BR_NEGATIVE 6'h02
`define BBF_OP_BR_POSITIVE 6'h03
`define BBF_OP_BR_SIGNED_GE 6'h04
`define BBF_OP_BR_SIGNED_LESS 6'h05
`define BBF_OP_BR_HALF_SET 6'h06
`define BBF_OP_BR_HALF_CLEAR 6'h07
`define BBF_OP_BR_TRANSFER_SET 6'h08
`define BBF_OP_BR_TRANSFER_CLEAR 6'h09
`define BBF_OP_BR_OVERFLOW_SET 6'h0a
`define BBF_OP_BR_OVERFLOW_CLEAR 6'h0b
`define BBF_OP_BR_INT_ENABLED 6'h0c
`define BBF_OP_BR_INT_DISABLED 6'h0d
`define BBF_OP_BR_LAST 6'h0d

// ------------------------------------------------------------
// operation codes: io bits, shifts, transfer bit, moves
// ------------------------------------------------------------
`define BBF_OP_SET_IO_BIT 6'h10
`define BBF_OP_CLEAR_IO_BIT 6'h11
`define BBF_OP_SHIFT_LEFT_LOGICAL 6'h12
`define BBF_OP_SHIFT_RIGHT_LOGICAL 6'h13
`define BBF_OP_ROTATE_LEFT_CARRY 6'h14
`define BBF_OP_ROTATE_RIGHT_CARRY 6'h15
`define BBF_OP_SHIFT_RIGHT_ARITH 6'h16
`define BBF_OP_STORE_BIT_TO_TRANSFER 6'h17
`define BBF_OP_LOAD_BIT_FROM_TRANSFER 6'h18
`define BBF_OP_COPY_REGISTER 6'h19
`define BBF_OP_COPY_REGISTER_PAIR 6'h1a
`define BBF_OP_LOAD_IMMEDIATE 6'h1b

// flag ops: 10_s_fff, s = 1 sets, fff = status bit index
`define BBF_OP_FLAG_BASE 2'h2
`define BBF_OP_FLAG_SET_BIT 3

// shift unit selects
`define BBF_SH_LSL 3'h0
`define BBF_SH_LSR 3'h1
`define BBF_SH_ROL 3'h2
`define BBF_SH_ROR 3'h3
`define BBF_SH_ASR 3'h4
// low op bits of the first shift code; subtracting it yields the select
`define BBF_SH_OP_BASE 3'h2

`endif

// ===== verilog/bbf_exec_unit.v
// execution unit for branches on flags, io bit ops, shifts, flag ops and moves
// Overview of operation
// - unsigned branches test carry, target pc+k+1
// - negative, half-carry, transfer flag branches both senses
// - overflow branches both senses, no flag change
// - signed branches test negative xor overflow
// - branches on global interrupt enable bit
// - io bit set/clear, two cycles, flags kept
// - logical left shift, zero in, flags updated
// - logical right shift, zero into bit seven
// - rotate left through carry, flags updated
// - rotate right through carry, flags updated
// - arithmetic right shift keeps sign bit
// - selected register bit copied into transfer flag
// - transfer flag copied into selected register bit
// - single-cycle set/clear of each status flag
// - global interrupt enable and disable ops
// - move, pair copy, load immediate, no flags
`timescale 1ns/1ns
`default_nettype none
`include "bbf_consts.vh"

module bbf_exec_unit #(
    parameter IO_COUNT = 32,
    parameter REG_COUNT = 32
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // instruction issue
    input wire instr_valid,
    input wire [5:0] instr_op,
    input wire [4:0] instr_rd,
    input wire [4:0] instr_rr,
    input wire [2:0] instr_bit,
    input wire [7:0] instr_imm,
    input wire [6:0] instr_offset,
    input wire [4:0] instr_io,
    // observation selects
    input wire [4:0] reg_sel,
    input wire [4:0] io_sel,
    // issue handshake and state
    output reg instr_ready,
    output reg retire,
    output reg [15:0] pc_out,
    output reg [7:0] status_out,
    output reg [7:0] reg_data,
    output reg [7:0] io_data
);

    // ------------------------------------------------------------
    // state machine codes
    // ------------------------------------------------------------
    // only taken branches and io bit ops ever visit the stall state
    localparam ST_ISSUE = 1'b0; // ready for a new instruction
    localparam ST_STALL = 1'b1; // second cycle of a two-cycle op

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [7:0] regs_reg [0:REG_COUNT-1]; // working registers
    reg [7:0] io_reg [0:IO_COUNT-1]; // io registers
    reg [15:0] pc_reg; // program counter
    reg [15:0] pc_next;
    reg [7:0] status_reg; // status register
    reg [7:0] status_next;
    reg state_reg; // issue / stall
    reg state_next;
    reg retire_next;

    // write-back controls for the destination register or pair and the io register
    reg rd_we; // write instr_rd
    reg [7:0] rd_wdata;
    reg pair_we; // write both registers of the even-aligned pair holding instr_rd
    // a pair copy reads both source bytes before either lands, so copying
    // a pair onto itself is harmless
    reg io_we; // write instr_io
    reg [7:0] io_wdata;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // branch condition from op code and current status
    function branch_cond;
        input [5:0] op;
        input [7:0] st;
        begin
            case (op)
                `BBF_OP_BR_SAME_OR_HIGHER: branch_cond = ~st[`BBF_FLAG_C];
                `BBF_OP_BR_LOWER: branch_cond = st[`BBF_FLAG_C];
                `BBF_OP_BR_NEGATIVE: branch_cond = st[`BBF_FLAG_N];
                `BBF_OP_BR_POSITIVE: branch_cond = ~st[`BBF_FLAG_N];
                `BBF_OP_BR_SIGNED_GE: begin
                    branch_cond = ~(st[`BBF_FLAG_N] ^ st[`BBF_FLAG_V]);
                end
                `BBF_OP_BR_SIGNED_LESS: begin
                    branch_cond = st[`BBF_FLAG_N] ^ st[`BBF_FLAG_V];
                end
                `BBF_OP_BR_HALF_SET: branch_cond = st[`BBF_FLAG_H];
                `BBF_OP_BR_HALF_CLEAR: branch_cond = ~st[`BBF_FLAG_H];
                `BBF_OP_BR_TRANSFER_SET: branch_cond = st[`BBF_FLAG_T];
                `BBF_OP_BR_TRANSFER_CLEAR: branch_cond = ~st[`BBF_FLAG_T];
                `BBF_OP_BR_OVERFLOW_SET: branch_cond = st[`BBF_FLAG_V];
                `BBF_OP_BR_OVERFLOW_CLEAR: branch_cond = ~st[`BBF_FLAG_V];
                `BBF_OP_BR_INT_ENABLED: branch_cond = st[`BBF_FLAG_I];
                `BBF_OP_BR_INT_DISABLED: branch_cond = ~st[`BBF_FLAG_I];
                default: branch_cond = 1'b0;
            endcase
        end
    endfunction

    // one-hot mask for a bit index, used by io and register bit ops
    function [7:0] bit_mask;
        input [2:0] idx;
        begin
            bit_mask = 8'h01 << idx;
        end
    endfunction

    // ------------------------------------------------------------
    // operand fetch and shift unit
    // ------------------------------------------------------------
    wire [7:0] rd_value = regs_reg[instr_rd];
    wire [7:0] rr_value = regs_reg[instr_rr];
    wire [7:0] io_value = io_reg[instr_io];
    wire [7:0] shift_result;
    wire shift_c;
    wire shift_z;
    wire shift_n;
    wire shift_v;
    // the five shift ops are contiguous, so the low op bits pick the shift
    wire [2:0] shift_sel = instr_op[2:0] - `BBF_SH_OP_BASE; // lsl..asr are 0x12..0x16
    // ready already covers the stall cycle; the state test is a second guard
    // so a stray valid can never start an op while the stall is still running
    wire accept = instr_valid & instr_ready & (state_reg == ST_ISSUE);
    wire is_flag_op = (instr_op[5:4] == `BBF_OP_FLAG_BASE);
    // sign-extended offset; the +1 skips past the branch itself
    wire [15:0] branch_target = pc_reg + {{9{instr_offset[`BBF_OFF_SIGN]}}, instr_offset}
        + `BBF_PC_STEP;

    bbf_shift_unit u_shift (
        .shift_sel(shift_sel),
        .value(rd_value),
        .carry_in(status_reg[`BBF_FLAG_C]),
        .result(shift_result),
        .carry_out(shift_c),
        .zero_out(shift_z),
        .negative_out(shift_n),
        .overflow_out(shift_v)
    );

    // ------------------------------------------------------------
    // execute: next pc, status, write-back and sequencing
    // ------------------------------------------------------------
    always @* begin
        pc_next = pc_reg;
        status_next = status_reg;
        state_next = ST_ISSUE;
        retire_next = 1'b0;
        rd_we = 1'b0;
        rd_wdata = rd_value;
        pair_we = 1'b0;
        io_we = 1'b0;
        io_wdata = io_value;
        if (state_reg == ST_STALL) begin
            // second cycle: work already done, now retire
            retire_next = 1'b1;
        end else if (accept) begin
            pc_next = pc_reg + `BBF_PC_STEP;
            retire_next = 1'b1;
            if (instr_op <= `BBF_OP_BR_LAST) begin
                // branches never touch status; taken costs one more cycle
                if (branch_cond(instr_op, status_reg)) begin
                    pc_next = branch_target;
                    state_next = ST_STALL;
                    retire_next = 1'b0;
                end
            end else if (is_flag_op) begin
                // only the named flag moves
                status_next[instr_op[2:0]] = instr_op[`BBF_OP_FLAG_SET_BIT];
            end else begin
                case (instr_op)
                    `BBF_OP_SET_IO_BIT: begin
                        io_we = 1'b1;
                        io_wdata = io_value | bit_mask(instr_bit);
                        state_next = ST_STALL;
                        retire_next = 1'b0;
                    end
                    `BBF_OP_CLEAR_IO_BIT: begin
                        io_we = 1'b1;
                        io_wdata = io_value & ~bit_mask(instr_bit);
                        state_next = ST_STALL;
                        retire_next = 1'b0;
                    end
                    `BBF_OP_SHIFT_LEFT_LOGICAL, `BBF_OP_SHIFT_RIGHT_LOGICAL,
                    `BBF_OP_ROTATE_LEFT_CARRY, `BBF_OP_ROTATE_RIGHT_CARRY,
                    `BBF_OP_SHIFT_RIGHT_ARITH: begin
                        rd_we = 1'b1;
                        rd_wdata = shift_result;
                        // z, c, n, v only; s and h are left alone
                        status_next[`BBF_FLAG_C] = shift_c;
                        status_next[`BBF_FLAG_Z] = shift_z;
                        status_next[`BBF_FLAG_N] = shift_n;
                        status_next[`BBF_FLAG_V] = shift_v;
                    end
                    `BBF_OP_STORE_BIT_TO_TRANSFER: begin
                        status_next[`BBF_FLAG_T] = rr_value[instr_bit];
                    end
                    `BBF_OP_LOAD_BIT_FROM_TRANSFER: begin
                        rd_we = 1'b1;
                        rd_wdata = status_reg[`BBF_FLAG_T] ? (rd_value | bit_mask(instr_bit))
                            : (rd_value & ~bit_mask(instr_bit));
                    end
                    `BBF_OP_COPY_REGISTER: begin
                        rd_we = 1'b1;
                        rd_wdata = rr_value;
                    end
                    `BBF_OP_COPY_REGISTER_PAIR: begin
                        pair_we = 1'b1;
                    end
                    `BBF_OP_LOAD_IMMEDIATE: begin
                        rd_we = 1'b1;
                        rd_wdata = instr_imm;
                    end
                    default: begin
                        // unknown op retires as a no-op
                        retire_next = 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // working registers; pair copy uses even-aligned pairs
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi = gi + 1) begin : g_regs
            always @(posedge clk) begin
                if (reset) begin
                    regs_reg[gi] <= `BBF_REG_RESET;
                end else if (rd_we && (instr_rd == gi)) begin
                    regs_reg[gi] <= rd_wdata;
                end else if (pair_we && (instr_rd[4:1] == gi / 2)) begin
                    // low byte from even source, high byte from odd
                    regs_reg[gi] <= regs_reg[{instr_rr[4:1], gi % 2 == 1}];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // io registers
    // ------------------------------------------------------------
    // bit ops rewrite the whole byte; there is no outside io bus here, so
    // nothing can change the register between the read and the write
    generate
        for (gi = 0; gi < IO_COUNT; gi = gi + 1) begin : g_io
            always @(posedge clk) begin
                if (reset) begin
                    io_reg[gi] <= `BBF_REG_RESET;
                end else if (io_we && (instr_io == gi)) begin
                    io_reg[gi] <= io_wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // sequencing, pc, status and registered outputs
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_ISSUE;
            pc_reg <= `BBF_PC_RESET;
            status_reg <= `BBF_STATUS_RESET;
            instr_ready <= 1'b0;
            retire <= 1'b0;
            pc_out <= `BBF_PC_RESET;
            status_out <= `BBF_STATUS_RESET;
            reg_data <= `BBF_REG_RESET;
            io_data <= `BBF_REG_RESET;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            status_reg <= status_next;
            // ready drops for the extra cycle of a two-cycle op
            instr_ready <= (state_next == ST_ISSUE);
            retire <= retire_next;
            // pc_out and status_out track the internal copies edge for edge
            pc_out <= pc_next;
            status_out <= status_next;
            // observation reads show the settled storage, one cycle late
            reg_data <= regs_reg[reg_sel];
            io_data <= io_reg[io_sel];
        end
    end

endmodule // bbf_exec_unit

`default_nettype wire

// ===== verilog/bbf_shift_unit.v
// shift and rotate datapath with its flag results
`timescale 1ns/1ns
`default_nettype none
`include "bbf_consts.vh"

module bbf_shift_unit (
    // operation select and operands
    input wire [2:0] shift_sel,
    input wire [7:0] value,
    input wire carry_in,
    // result and flags
    output reg [7:0] result,
    output reg carry_out,
    output wire zero_out,
    output wire negative_out,
    output wire overflow_out
);

    // ------------------------------------------------------------
    // result and carry
    // ------------------------------------------------------------
    always @* begin
        case (shift_sel)
            `BBF_SH_LSL: begin
                result = {value[6:0], 1'b0};
                carry_out = value[7];
            end
            `BBF_SH_LSR: begin
                result = {1'b0, value[7:1]};
                carry_out = value[0];
            end
            `BBF_SH_ROL: begin
                result = {value[6:0], carry_in};
                carry_out = value[7];
            end
            `BBF_SH_ROR: begin
                result = {carry_in, value[7:1]};
                carry_out = value[0];
            end
            `BBF_SH_ASR: begin
                result = {value[7], value[7:1]};
                carry_out = value[0];
            end
            default: begin
                // unused select, pass through
                result = value;
                carry_out = carry_in;
            end
        endcase
    end

    // flags derived from the result; overflow is negative xor carry
    assign zero_out = (result == 8'h00);
    assign negative_out = result[7];
    assign overflow_out = result[7] ^ carry_out;

endmodule // bbf_shift_unit

`default_nettype wire
